// >>> adaptive_sample_record_builder.v
// Adaptive sample record builder: AHB-Lite register slave plus a word
// streamer that packs the selected groups into a record for the buffer.
// Assumes the core answers src_data in the same cycle as src_group/index.
//
// Overview of operation
// [RULE_01] Basic group always first, four words
// [RULE_02] Config bit 0 adds memory group
// [RULE_03] Config bit 1 adds general registers
// [RULE_04] Config bit 2 adds sixteen vector registers
// [RULE_05] Config bit 3 adds branch history entries
// [RULE_06] Entry is source, destination, info words
// [RULE_07] Entry count is field 31:24 plus one
// [RULE_08] Software should program odd entry counts
// [RULE_09] Walk from top entry to older ones
// [RULE_10] Entry index wraps modulo implemented entries
// [RULE_11] Reserved config bit written raises fault
// [RULE_12] Config writes ignored while monitoring unavailable
// [RULE_13] Fixed order basic, memory, registers, vector, history
// [RULE_14] Omitted groups leave no gap
// [RULE_15] Unsupported features emit zero fields
// [RULE_16] Outside long mode zero upper register halves
// [RULE_17] Vector group zero when extensions disabled
// [RULE_18] Size field holds emitted byte length
`timescale 1ns/1ps
`default_nettype none
`include "record_builder_consts.vh"

module adaptive_sample_record_builder (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire hresp,
    output reg [31:0] hrdata,
    input wire sample_req,
    input wire [7:0] history_top_index,
    input wire long_mode,
    input wire vec_enable,
    output wire [2:0] src_group,
    output wire [7:0] src_index,
    output wire [1:0] src_field,
    input wire [63:0] src_data,
    output reg rec_valid_r,
    output reg [63:0] rec_data_r,
    output reg rec_last_r,
    input wire rec_ready,
    output wire irq
);
    // ==========================================================
    // State codes
    localparam ST_IDLE = 1'b0;
    localparam ST_EMIT = 1'b1;

    // ==========================================================
    // Register bus state
    reg wr_pend_r; // Write data phase pending
    reg [7:0] addr_r; // Address captured in address phase
    reg [31:0] cfg_r; // Group selection and entry count
    reg ctrl_r; // Performance monitoring available
    reg [2:0] status_r; // Sticky events
    reg [2:0] mask_r; // Interrupt enables
    reg [15:0] last_size_r; // Byte size of the last finished record

    // Streamer state
    reg state_r;
    reg [31:0] cfg_act_r; // Snapshot so a write cannot tear a record
    reg [10:0] word_r; // Word cursor within the record
    reg [7:0] hist_idx_r; // Entry being emitted
    reg [1:0] sub_r; // Field within the entry

    // ==========================================================
    // Layout of the active record
    wire [10:0] mem_start;
    wire [10:0] gpr_start;
    wire [10:0] vec_start;
    wire [10:0] hist_start;
    wire [10:0] total_words;
    wire [15:0] size_bytes;

    record_layout u_layout (
        .groups(cfg_act_r[`CFG_GRP_HI:0]),
        .hist_cnt_m1(cfg_act_r[`CFG_CNT_HI:`CFG_CNT_LO]),
        .mem_start(mem_start),
        .gpr_start(gpr_start),
        .vec_start(vec_start),
        .hist_start(hist_start),
        .total_words(total_words)
    );

    assign size_bytes = {2'h0, total_words, `BYTE_SHIFT'h0}; // RULE_18

    // ==========================================================
    // Group that owns a word position; empty groups have zero span
    function [2:0] grp_of;
        input [10:0] w;
        input [10:0] m;
        input [10:0] g;
        input [10:0] v;
        input [10:0] h;
        begin
            if (w < m) begin
                grp_of = `GRP_BASIC;
            end else if (w < g) begin
                grp_of = `GRP_MEM;
            end else if (w < v) begin
                grp_of = `GRP_GPR;
            end else if (w < h) begin
                grp_of = `GRP_VEC;
            end else begin
                grp_of = `GRP_HIST;
            end
        end
    endfunction

    wire [2:0] cur_grp; // Group of the word at the cursor
    assign cur_grp = grp_of(word_r, mem_start, gpr_start, vec_start,
        hist_start); // RULE_13 RULE_14

    // Word index within the current group
    reg [10:0] gidx;
    always @* begin
        case (cur_grp)
            `GRP_MEM: gidx = word_r - mem_start;
            `GRP_GPR: gidx = word_r - gpr_start;
            `GRP_VEC: gidx = word_r - vec_start;
            `GRP_HIST: gidx = word_r - hist_start;
            default: gidx = word_r;
        endcase
    end

    // ==========================================================
    // Source read port; vector registers are two words, low first
    assign src_group = cur_grp;
    assign src_index = (cur_grp == `GRP_HIST) ? hist_idx_r :
        (cur_grp == `GRP_VEC) ? {3'h0, gidx[5:1]} : gidx[7:0];
    assign src_field = (cur_grp == `GRP_HIST) ? sub_r :
        (cur_grp == `GRP_VEC) ? {1'b0, gidx[0]} : 2'h0; // RULE_06

    // ==========================================================
    // Word shaping: zero fill for absent features and narrow modes
    reg [63:0] word_val;
    always @* begin
        word_val = 64'h0;
        case (cur_grp)
            `GRP_BASIC: begin
                if (gidx == 11'h000) begin
                    // Format carries the active selection
                    word_val[`SIZE_HI:`SIZE_LO] = size_bytes; // RULE_18
                    word_val[31:0] = cfg_act_r; // RULE_01
                end else begin
                    word_val = src_data; // RULE_01
                end
            end
            `GRP_MEM: begin
                word_val = `HAS_MEM ? src_data : 64'h0; // RULE_02 RULE_15
            end
            `GRP_GPR: begin
                if (!`HAS_GPR) begin
                    word_val = 64'h0; // RULE_15
                end else if (long_mode) begin
                    word_val = src_data; // RULE_03
                end else if (gidx >= `GPR_EXT_LO) begin
                    word_val = 64'h0; // RULE_16
                end else if (gidx >= `GPR_LEGACY_LO) begin
                    word_val = {32'h0, src_data[31:0]}; // RULE_16
                end else begin
                    word_val = src_data; // RULE_03
                end
            end
            `GRP_VEC: begin
                if (!`HAS_VEC || !vec_enable) begin
                    word_val = 64'h0; // RULE_15 RULE_17
                end else if (!long_mode && gidx >= `VEC_EXT_LO) begin
                    word_val = 64'h0; // Upper eight absent in narrow mode
                end else begin
                    word_val = src_data; // RULE_04
                end
            end
            `GRP_HIST: begin
                word_val = `HAS_HIST ? src_data : 64'h0; // RULE_05 RULE_15
            end
            default: begin
                word_val = 64'h0;
            end
        endcase
    end

    // ==========================================================
    // Streamer: one word per accepted slot of the output register
    wire load; // Output register free to take the next word
    wire last_word;
    wire start;
    assign load = (state_r == ST_EMIT) && (!rec_valid_r || rec_ready);
    assign last_word = (word_r == total_words - 11'h001);
    assign start = sample_req && (state_r == ST_IDLE);

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= ST_IDLE;
            cfg_act_r <= `CFG_RESET;
            word_r <= 11'h000;
            hist_idx_r <= 8'h00;
            sub_r <= 2'h0;
            rec_valid_r <= 1'b0;
            rec_data_r <= 64'h0;
            rec_last_r <= 1'b0;
            last_size_r <= 16'h0;
        end else begin
            if (rec_valid_r && rec_ready && !load) begin
                rec_valid_r <= 1'b0;
            end
            case (state_r)
                ST_IDLE: begin
                    if (start) begin
                        cfg_act_r <= cfg_r;
                        word_r <= 11'h000;
                        hist_idx_r <= history_top_index; // RULE_09
                        sub_r <= 2'h0;
                        state_r <= ST_EMIT;
                    end
                end
                ST_EMIT: begin
                    if (load) begin
                        rec_valid_r <= 1'b1;
                        rec_data_r <= word_val;
                        rec_last_r <= last_word;
                        word_r <= word_r + 11'h001;
                        if (cur_grp == `GRP_HIST) begin
                            if (sub_r == `HIST_FIELDS) begin
                                sub_r <= 2'h0;
                                // Next older entry, wrapping at zero
                                if (hist_idx_r == 8'h00) begin
                                    hist_idx_r <=
                                        `HIST_ENTRIES - 8'h01; // RULE_10
                                end else begin
                                    hist_idx_r <=
                                        hist_idx_r - 8'h01; // RULE_09
                                end
                            end else begin
                                sub_r <= sub_r + 2'h1; // RULE_06
                            end
                        end
                        if (last_word) begin
                            last_size_r <= size_bytes;
                            state_r <= ST_IDLE;
                        end
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // AHB-Lite slave: zero wait states, always OKAY
    wire acc; // Valid address phase for this slave
    assign acc = hsel && hready && htrans[1];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            addr_r <= 8'h00;
        end else begin
            if (hready) begin
                wr_pend_r <= acc && hwrite;
            end
            if (acc) begin
                addr_r <= haddr[7:0];
            end
        end
    end

    // Write decode in the data phase
    wire cfg_wr;
    wire cfg_bad;
    wire cfg_take;
    assign cfg_wr = wr_pend_r && (addr_r == `REG_CFG) && ctrl_r; // RULE_12
    assign cfg_bad = |hwdata[`CFG_RSV_HI:`CFG_RSV_LO]; // RULE_11
    assign cfg_take = cfg_wr && !cfg_bad;

    // Events; a faulting write leaves the configuration untouched
    wire [2:0] evt;
    assign evt[`STAT_DONE] = load && last_word;
    assign evt[`STAT_FAULT] = cfg_wr && cfg_bad; // RULE_11
    assign evt[`STAT_DROP] = sample_req && (state_r != ST_IDLE);

    wire [2:0] w1c; // Write one to clear
    assign w1c = (wr_pend_r && (addr_r == `REG_STATUS)) ?
        hwdata[2:0] : 3'h0;

    // Register file; a set in the clearing cycle still wins
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_r <= `CFG_RESET;
            ctrl_r <= 1'b0;
            status_r <= 3'h0;
            mask_r <= 3'h0;
        end else begin
            if (cfg_take) begin
                cfg_r <= hwdata & `CFG_WR_MASK; // RULE_07
            end
            if (wr_pend_r && (addr_r == `REG_CTRL)) begin
                ctrl_r <= hwdata[`CTRL_PERF];
            end
            if (wr_pend_r && (addr_r == `REG_MASK)) begin
                mask_r <= hwdata[2:0];
            end
            status_r <= (status_r & ~w1c) | evt;
        end
    end

    assign irq = |(status_r & mask_r);

    // Read mux in the data phase; unmapped reads return zero
    always @* begin
        case (addr_r)
            `REG_CFG: hrdata = cfg_r;
            `REG_CTRL: hrdata = {31'h0, ctrl_r};
            `REG_STATUS: hrdata = {29'h0, status_r};
            `REG_MASK: hrdata = {29'h0, mask_r};
            `REG_INFO: hrdata = {state_r, 15'h0, last_size_r};
            default: hrdata = 32'h0;
        endcase
    end
endmodule
`default_nettype wire

// >>> record_builder_consts.vh
// Constants shared by the sample record builder and its layout helper.
// Assumes inclusion by bare name from files in the same folder.
`ifndef RECORD_BUILDER_CONSTS_VH
`define RECORD_BUILDER_CONSTS_VH

// ==========================================================
// Register byte addresses (low address bits only)
`define ADDR_W 8
`define REG_CFG 8'h00
`define REG_CTRL 8'h04
`define REG_STATUS 8'h08
`define REG_MASK 8'h0C
`define REG_INFO 8'h10

// ==========================================================
// Configuration register fields
`define CFG_MEM 0
`define CFG_GPR 1
`define CFG_VEC 2
`define CFG_HIST 3
`define CFG_GRP_HI 3
`define CFG_RSV_HI 23
`define CFG_RSV_LO 4
`define CFG_CNT_HI 31
`define CFG_CNT_LO 24
`define CFG_RESET 32'h0000_0000
`define CFG_WR_MASK 32'hFF00_000F

// Control register: performance monitoring available flag
`define CTRL_PERF 0
`define STAT_BITS 3
`define STAT_DONE 0
`define STAT_FAULT 1
`define STAT_DROP 2
`define INFO_BUSY 31

// ==========================================================
// Record layout, in 64-bit words
`define WORD_CNT_W 11
`define BASIC_WORDS 11'h004
`define MEM_WORDS 11'h004
`define GPR_WORDS 11'h012
`define VEC_WORDS 11'h020
`define HIST_FIELDS 2'h2
`define GPR_LEGACY_LO 11'h002
`define GPR_EXT_LO 11'h00A
`define VEC_EXT_LO 11'h010
`define SIZE_HI 63
`define SIZE_LO 48
`define BYTE_SHIFT 3

// Group codes on the source read port
`define GRP_BASIC 3'h0
`define GRP_MEM 3'h1
`define GRP_GPR 3'h2
`define GRP_VEC 3'h3
`define GRP_HIST 3'h4

// ==========================================================
// Implementation: history depth and supported features
`define HIST_ENTRIES 8'h20
`define HAS_MEM 1'b1
`define HAS_GPR 1'b1
`define HAS_VEC 1'b1
`define HAS_HIST 1'b1

`endif

// >>> record_layout.v
// Start word of each record group and total record length in words.
// Assumes the group enables and entry count of the active configuration.
`timescale 1ns/1ps
`default_nettype none
`include "record_builder_consts.vh"

module record_layout (
    input wire [3:0] groups,
    input wire [7:0] hist_cnt_m1,
    output wire [10:0] mem_start,
    output wire [10:0] gpr_start,
    output wire [10:0] vec_start,
    output wire [10:0] hist_start,
    output wire [10:0] total_words
);
    // ==========================================================
    // Group sizes
    wire [10:0] n_entries; // Entry field plus one
    wire [10:0] hist_words; // Three words per entry
    assign n_entries = {3'h0, hist_cnt_m1} + 11'h001; // RULE_07
    assign hist_words = groups[`CFG_HIST] ?
        ({n_entries[9:0], 1'b0} + n_entries) : 11'h000; // RULE_05 RULE_06

    // ==========================================================
    // Omitted groups take no room, so starts simply accumulate
    assign mem_start = `BASIC_WORDS; // RULE_01
    assign gpr_start = mem_start +
        (groups[`CFG_MEM] ? `MEM_WORDS : 11'h000); // RULE_13 RULE_14
    assign vec_start = gpr_start +
        (groups[`CFG_GPR] ? `GPR_WORDS : 11'h000); // RULE_13 RULE_14
    assign hist_start = vec_start +
        (groups[`CFG_VEC] ? `VEC_WORDS : 11'h000); // RULE_13 RULE_14
    assign total_words = hist_start + hist_words; // RULE_18
endmodule
`default_nettype wire

// >>> record_sink_model.sv
// Model of the core register source and the sample buffer beside the builder.
// Assumes one clock; answers src_data in the cycle of the request.
`timescale 1ns/1ps
`default_nettype none
module record_sink_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic stall,
    input wire logic [2:0] src_group,
    input wire logic [7:0] src_index,
    input wire logic [1:0] src_field,
    output logic [63:0] src_data,
    output logic rec_ready
);
    // ==========================================
    // Source answer: group, index, field in both halves, so zeroing shows
    assign src_data = {16'hC0DE, 3'h0, src_group, src_index, src_field,
                       16'hA5A5, 3'h0, src_group, src_index, src_field};
    logic [1:0] cyc_r; // Stall phase counter
    // Buffer accepts every cycle, or one in four when stalling
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cyc_r <= 2'h0;
            rec_ready <= 1'b0;
        end else begin
            cyc_r <= cyc_r + 2'h1;
            rec_ready <= !stall || (cyc_r == 2'h2);
        end
    end
endmodule
`default_nettype wire

// >>> record_builder_assertions.sv
// Checker on the builder's bus answers and record stream.
// Assumes it is bound to the builder; one clock, async active-low reset.
`timescale 1ns/1ps
`default_nettype none
`include "record_builder_consts.vh"
module record_builder_checker (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic sample_req,
    input wire logic [2:0] src_group,
    input wire logic [7:0] src_index,
    input wire logic [1:0] src_field,
    input wire logic rec_valid_r,
    input wire logic [63:0] rec_data_r,
    input wire logic rec_last_r,
    input wire logic rec_ready
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // ==========================================
    // Record tracking
    logic busy_r; // Record under way
    logic [7:0] cnt_r; // Words handed over; 255 at most fits
    logic [15:0] size_r; // Size field of word 0
    logic [31:0] fmt_r; // Config snapshot of word 0
    wire acc = sample_req && !busy_r && !rec_valid_r;
    wire hs = rec_valid_r && rec_ready;
    // Byte length implied by a config snapshot
    function automatic [15:0] exp_bytes(input [31:0] c);
        exp_bytes = 16'h20 + (c[0] ? 16'h20 : 16'h0)
            + (c[1] ? 16'h90 : 16'h0) + (c[2] ? 16'h100 : 16'h0)
            + (c[3] ? 16'h18 * ({8'h0, c[31:24]} + 16'h1) : 16'h0);
    endfunction
    // Helper state follows each handshake
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            busy_r <= 1'b0;
            cnt_r <= 8'h0;
            size_r <= 16'h0;
            fmt_r <= 32'h0;
        end else begin
            if (acc) begin
                busy_r <= 1'b1;
            end else if (hs && rec_last_r) begin
                busy_r <= 1'b0;
            end
            if (hs) begin
                cnt_r <= rec_last_r ? 8'h0 : cnt_r + 8'h1;
            end
            if (hs && cnt_r == 8'h0) begin
                size_r <= rec_data_r[63:48];
                fmt_r <= rec_data_r[31:0];
            end
        end
    end
    // ==========================================
    // Assertions
    a_bus_okay: assert property (hresp == 1'b0 && hreadyout == 1'b1)
        else $error("bus answer not zero-wait okay");
    a_first_word: assert property (acc
        |=> !rec_valid_r ##1 rec_valid_r)
        else $error("first record word not two edges after request");
    a_word0_fmt: assert property (busy_r && rec_valid_r
        && cnt_r == 8'h0
        |-> rec_data_r[47:32] == 16'h0 && rec_data_r[23:4] == 20'h0)
        else $error("word 0 format bits wrong");
    a_word_hold: assert property (rec_valid_r && !rec_ready
        |=> rec_valid_r && $stable(rec_data_r) && $stable(rec_last_r))
        else $error("record word changed while stalled");
    a_size_count: assert property (hs && rec_last_r
        |-> {5'h0, cnt_r, 3'h0} + 16'h8 == size_r)
        else $error("size field differs from words sent");
    a_size_layout: assert property (hs && rec_last_r
        |-> size_r == exp_bytes(fmt_r))
        else $error("size field differs from selected groups");
    a_hist_index: assert property (busy_r && !rec_last_r
        && src_group == `GRP_HIST
        |-> src_index < `HIST_ENTRIES && src_field <= 2'h2)
        else $error("history index or field out of range");
    a_last_done: assert property (hs && rec_last_r
        |=> !rec_valid_r)
        else $error("words continue after the last one");
    c_full_record: cover property (hs && rec_last_r && size_r == 16'h4D0);
    c_stalled: cover property (rec_valid_r && !rec_ready);
    c_hist_wrap: cover property (busy_r && src_group == `GRP_HIST
        && src_index == 8'h1F);
endmodule
bind adaptive_sample_record_builder record_builder_checker i_chk (
    .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
    .sample_req(sample_req), .src_group(src_group),
    .src_index(src_index), .src_field(src_field),
    .rec_valid_r(rec_valid_r), .rec_data_r(rec_data_r),
    .rec_last_r(rec_last_r), .rec_ready(rec_ready));
`default_nettype wire

// >>> adaptive_sample_record_builder_tb.sv
// Self-checking bench: AHB-Lite register access and record layouts.
// Assumes the sink model answers the source port and drives rec_ready.
`timescale 1ns/1ps
`default_nettype none
`include "record_builder_consts.vh"
module adaptive_sample_record_builder_tb;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2, src_group;
    logic hreadyout, hresp, sample_req = 1'b0, long_mode = 1'b1;
    logic vec_enable = 1'b1, stall = 1'b0, rec_valid_r, rec_last_r;
    logic rec_ready, irq;
    logic [7:0] history_top_index = 8'h0, src_index;
    logic [1:0] src_field;
    logic [63:0] src_data, rec_data_r;
    logic [63:0] w [0:199]; // Captured record words
    logic [31:0] rd;
    int n_fail = 0, tests_run = 0, cyc = 0;
    adaptive_sample_record_builder i_adaptive_sample_record_builder (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .sample_req(sample_req),
        .history_top_index(history_top_index), .long_mode(long_mode),
        .vec_enable(vec_enable), .src_group(src_group),
        .src_index(src_index), .src_field(src_field), .src_data(src_data),
        .rec_valid_r(rec_valid_r), .rec_data_r(rec_data_r),
        .rec_last_r(rec_last_r), .rec_ready(rec_ready), .irq(irq));
    record_sink_model i_record_sink_model (.hclk(hclk), .hresetn(hresetn),
        .stall(stall), .src_group(src_group), .src_index(src_index),
        .src_field(src_field), .src_data(src_data), .rec_ready(rec_ready));
    // ==========================================
    // Clock and hang guard; longest run is under a thousand cycles
    initial begin
        forever #2.5 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail = n_fail + 1;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        tests_run = tests_run + 1;
        if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // ==========================================
    // Bus master: address phase held until hready, then data phase
    task automatic ahb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wr ? d : 32'h0;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    // Word check by group; mode 2 full, 1 upper half zero, 0 all zero
    task automatic chk_g(input logic [63:0] v, input logic [2:0] g,
                         input int mode);
        chk(v[63:32], mode == 2 ? {16'hC0DE, 3'h0, g, v[41:32]} : 32'h0);
        chk(v[31:0], mode != 0 ? {16'hA5A5, 3'h0, g, v[9:0]} : 32'h0);
    endtask
    // ==========================================
    // Reset values, unmapped place, write gate, reserved fault, interrupt
    task automatic reg_test();
        for (int i = 0; i < 6; i++) begin
            ahb(1'b0, 8'(i * 4), 32'h0);
            chk(rd, 32'h0);
        end
        ahb(1'b1, 8'h14, 32'hFFFF_FFFF);
        ahb(1'b0, 8'h14, 32'h0);
        chk(rd, 32'h0);
        ahb(1'b1, `REG_CFG, 32'h0000_000F);
        ahb(1'b0, `REG_CFG, 32'h0);
        chk(rd, 32'h0);
        ahb(1'b1, `REG_CTRL, 32'h0000_0001);
        ahb(1'b1, `REG_CFG, 32'h0080_0010);
        ahb(1'b0, `REG_CFG, 32'h0);
        chk(rd, 32'h0);
        ahb(1'b0, `REG_STATUS, 32'h0);
        chk(rd, 32'h2);
        @(posedge hclk) chk(irq, 1'b0);
        ahb(1'b1, `REG_MASK, 32'h2);
        @(posedge hclk) chk(irq, 1'b1);
        ahb(1'b1, `REG_STATUS, 32'h2);
        @(posedge hclk) chk(irq, 1'b0);
    endtask
    // ==========================================
    // One record with the given config, captured and compared word by word
    // Request stands two edges: the second is dropped while busy
    task automatic run_rec(input logic [31:0] cfg, input logic [7:0] top,
                           input logic lm, input logic ve, input logic st);
        int n, o, nh, tot;
        logic done;
        ahb(1'b1, `REG_CFG, cfg);
        ahb(1'b0, `REG_CFG, 32'h0);
        chk(rd, cfg);
        history_top_index <= top;
        long_mode <= lm;
        vec_enable <= ve;
        stall <= st;
        sample_req <= 1'b1;
        repeat (2) @(posedge hclk);
        sample_req <= 1'b0;
        n = 0;
        done = 1'b0;
        while (!done) begin
            @(posedge hclk);
            if (rec_valid_r === 1'b1 && rec_ready === 1'b1) begin
                w[n] = rec_data_r;
                done = rec_last_r;
                n++;
            end
        end
        nh = cfg[3] ? cfg[31:24] + 1 : 0;
        tot = 4 + (cfg[0] ? 4 : 0) + (cfg[1] ? 18 : 0) + (cfg[2] ? 32 : 0)
            + 3 * nh;
        chk(n, tot);
        chk(w[0][63:32], {tot[12:0], 3'h0, 16'h0});
        chk(w[0][31:0], cfg);
        for (int k = 1; k < 4; k++) chk_g(w[k], `GRP_BASIC, 2);
        o = 4;
        if (cfg[0]) for (int j = 0; j < 4; j++)
            chk_g(w[o + j], `GRP_MEM, 2);
        o += cfg[0] ? 4 : 0;
        if (cfg[1]) for (int j = 0; j < 18; j++)
            chk_g(w[o + j], `GRP_GPR,
                (lm || j < 2) ? 2 : (j < 10) ? 1 : 0);
        o += cfg[1] ? 18 : 0;
        if (cfg[2]) for (int j = 0; j < 32; j++)
            chk_g(w[o + j], `GRP_VEC,
                (ve && (lm || j < 16)) ? 2 : 0);
        o += cfg[2] ? 32 : 0;
        for (int e = 0; e < nh; e++) for (int f = 0; f < 3; f++)
            chk_g(w[o + 3 * e + f], `GRP_HIST, 2);
        for (int e = 0; e < nh; e++) for (int f = 0; f < 3; f++)
            chk(w[o + 3 * e + f][9:0],
                {(top - 8'(e)) & 8'h1F, 2'(f)});
        ahb(1'b0, `REG_STATUS, 32'h0);
        chk(rd[2:0], 3'h5);
        ahb(1'b1, `REG_STATUS, 32'h5);
        ahb(1'b0, `REG_INFO, 32'h0);
        chk(rd, {16'h0, tot[12:0], 3'h0});
    endtask
    // ==========================================
    // Main sequence
    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        reg_test();
        run_rec(32'h0100_000F, 8'h00, 1'b1, 1'b1, 1'b1);
        run_rec(32'h0500_0000, 8'h03, 1'b1, 1'b1, 1'b0);
        run_rec(32'h0200_000E, 8'h01, 1'b0, 1'b1, 1'b1);
        run_rec(32'h0000_0005, 8'h03, 1'b1, 1'b0, 1'b0);
        run_rec(32'h1F00_000F, 8'h07, 1'b1, 1'b1, 1'b0);
        print_verdict();
    end
endmodule
`default_nettype wire
